// ---- common/gti_pkg.sv ----
// Notes on behaviour
// - Byte reads of three registers at distinct addresses
// - Mode and enable set: watchdog mode counting up
// - Watchdog overflow drives overflow pin 128 cycles
// - Reset enable: chip reset starts with overflow pin
// - Reset select picks power-on or manual reset
// - Internal chip reset lasts 512 cycles
// - Pin reset wins and clears watchdog flag
// - Interval mode: interrupt request on every overflow outside standby
// - Interval overflow sets interval flag
// - Watchdog overflow sets watchdog flag
// - Standby refused while enable bit set
// - Standby wake: count, overflow ends standby
// - Counter write beats coincident count tick
// - No reset enable: reinit counter and control
// - Keyed word write: 5A counter, A5 control
// - Reset register keyed: A5 clears flag, 5A bits
// - Rate select: divide 2 to 8192
// - Disabled counter held at zero
package gti_pkg;
  localparam logic [27:0] GTI_ADDR_CTRL = 28'h5FFFFB8;
  localparam logic [27:0] GTI_ADDR_CNT = 28'h5FFFFB9;
  localparam logic [27:0] GTI_ADDR_RST_WR = 28'h5FFFFBA;
  localparam logic [27:0] GTI_ADDR_RST_RD = 28'h5FFFFBB;
  localparam logic [7:0] GTI_KEY_CNT = 8'h5A;
  localparam logic [7:0] GTI_KEY_CTRL = 8'hA5;
  localparam logic [7:0] GTI_CTRL_RSV = 8'h18;
  localparam logic [7:0] GTI_RST_RSV = 8'h1F;
  localparam int GTI_BIT_OVF = 7;
  localparam int GTI_BIT_MODE = 6;
  localparam int GTI_BIT_EN = 5;
  localparam int GTI_BIT_CHIP_RESET_ENABLE = 6;
  localparam int GTI_BIT_RESET_TYPE_SELECT = 5;
  localparam int GTI_PIN_NS = 1024;
  localparam int GTI_CHIP_RST_NS = 4096;
  localparam int GTI_CLK_PS = 8000;
  localparam int GTI_PIN_CYC = (GTI_PIN_NS * 1000) / GTI_CLK_PS;
  localparam int GTI_CHIP_RST_CYC = (GTI_CHIP_RST_NS * 1000) / GTI_CLK_PS;
  localparam int GTI_PRE_W = 13;

  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [27:0] addr;
    logic [15:0] wdata;
  } gti_bus_t;

  typedef struct packed {
    logic mode_wd;
    logic run_en;
    logic [2:0] prescale_select;
  } gti_ctrl_t;
endpackage

// ---- logic/gti_timer.sv ----
`timescale 1ns/1ps
module gti_timer
  import gti_pkg::*;
#(
  parameter int PIN_CYCLES = GTI_PIN_CYC,
  parameter int CHIP_RST_CYCLES = GTI_CHIP_RST_CYC
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire gti_bus_t bus,
  input wire logic standby_req,
  input wire logic nmi_wake,
  output logic [7:0] rdata,
  output logic overflow_out_n,
  output logic interval_irq,
  output logic chip_reset,
  output logic chip_reset_manual,
  output logic standby_active,
  output logic standby_refused
);
  if (PIN_CYCLES < 1 || PIN_CYCLES > 4095 || CHIP_RST_CYCLES < 1 || CHIP_RST_CYCLES > 4095)
  begin
    $error("gti_timer: pulse lengths out of range");
  end

  // ****************************************
  // Prescaler tap decode
  // ****************************************
  function automatic logic tap(input logic [2:0] sel, input logic [GTI_PRE_W-1:0] pre);
    logic [GTI_PRE_W-1:0] mask;
    mask = '0;
    case (sel)
      3'h0: mask = 13'h0001;
      3'h1: mask = 13'h003F;
      3'h2: mask = 13'h007F;
      3'h3: mask = 13'h00FF;
      3'h4: mask = 13'h01FF;
      3'h5: mask = 13'h03FF;
      3'h6: mask = 13'h0FFF;
      default: mask = 13'h1FFF;
    endcase
    return ((pre & mask) == mask);
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {GTI_RUN, GTI_STANDBY, GTI_WAKE} gti_pwr_t;

  gti_ctrl_t ctrl_reg, ctrl_next;
  logic ovf_reg, ovf_next;
  logic [7:0] cnt_reg, cnt_next;
  logic watch_overflow_flag_reg, watch_overflow_flag_next;
  logic chip_reset_enable_reg, chip_reset_enable_next;
  logic reset_type_select_reg, reset_type_select_next;
  logic [GTI_PRE_W-1:0] pre_reg, pre_next;
  logic [11:0] pin_cnt_reg, pin_cnt_next;
  logic [11:0] rst_cnt_reg, rst_cnt_next;
  logic manual_reg, manual_next;
  gti_pwr_t pwr_reg, pwr_next;
  logic irq_reg, irq_next;
  logic refused_reg, refused_next;
  logic [7:0] rdata_reg, rdata_next;

  logic tick;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_rst;
  logic counting;
  logic wrap;

  always_comb
  begin
    counting = (ctrl_reg.run_en && pwr_reg == GTI_RUN) || pwr_reg == GTI_WAKE;
    tick = counting && tap(ctrl_reg.prescale_select, pre_reg);
    wr_cnt = bus.wr && bus.word && bus.addr == GTI_ADDR_CTRL && bus.wdata[15:8] == GTI_KEY_CNT;
    wr_ctrl = bus.wr && bus.word && bus.addr == GTI_ADDR_CTRL && bus.wdata[15:8] == GTI_KEY_CTRL;
    wr_rst = bus.wr && bus.word && bus.addr == GTI_ADDR_RST_WR;
    wrap = tick && !wr_cnt && cnt_reg == 8'hFF;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ovf_next = ovf_reg;
    cnt_next = cnt_reg;
    watch_overflow_flag_next = watch_overflow_flag_reg;
    chip_reset_enable_next = chip_reset_enable_reg;
    reset_type_select_next = reset_type_select_reg;
    pre_next = counting ? pre_reg + 1'b1 : '0;
    pin_cnt_next = pin_cnt_reg;
    rst_cnt_next = rst_cnt_reg;
    manual_next = manual_reg;
    pwr_next = pwr_reg;
    irq_next = 1'b0;
    refused_next = 1'b0;
    rdata_next = 8'h00;
    if (wr_ctrl)
    begin
      ctrl_next = {bus.wdata[GTI_BIT_MODE], bus.wdata[GTI_BIT_EN], bus.wdata[2:0]};
      if (!bus.wdata[GTI_BIT_OVF])
      begin
        ovf_next = 1'b0;
      end
    end
    if (wr_rst && bus.wdata[15:8] == GTI_KEY_CTRL && bus.wdata[7:0] == 8'h00)
    begin
      watch_overflow_flag_next = 1'b0;
    end
    if (wr_rst && bus.wdata[15:8] == GTI_KEY_CNT)
    begin
      chip_reset_enable_next = bus.wdata[GTI_BIT_CHIP_RESET_ENABLE];
      reset_type_select_next = bus.wdata[GTI_BIT_RESET_TYPE_SELECT];
    end
    if (wr_cnt)
    begin
      cnt_next = bus.wdata[7:0];
    end
    else if (!counting)
    begin
      cnt_next = 8'h00;
    end
    else if (tick)
    begin
      cnt_next = cnt_reg + 8'h01;
    end
    if (pin_cnt_reg != 12'h000)
    begin
      pin_cnt_next = pin_cnt_reg - 12'h001;
    end
    if (rst_cnt_reg != 12'h000)
    begin
      rst_cnt_next = rst_cnt_reg - 12'h001;
    end
    if (wrap && pwr_reg == GTI_RUN && ctrl_reg.mode_wd)
    begin
      watch_overflow_flag_next = 1'b1;
      pin_cnt_next = 12'(PIN_CYCLES);
      if (chip_reset_enable_reg)
      begin
        rst_cnt_next = 12'(CHIP_RST_CYCLES);
        manual_next = reset_type_select_reg;
      end
      else
      begin
        ctrl_next = '0;
        ovf_next = 1'b0;
        cnt_next = 8'h00;
      end
    end
    if (wrap && pwr_reg == GTI_RUN && !ctrl_reg.mode_wd)
    begin
      ovf_next = 1'b1;
      irq_next = 1'b1;
    end
    case (pwr_reg)
      GTI_RUN:
      begin
        if (standby_req)
        begin
          if (ctrl_reg.run_en)
          begin
            refused_next = 1'b1;
          end
          else
          begin
            pwr_next = GTI_STANDBY;
            watch_overflow_flag_next = 1'b0;
            chip_reset_enable_next = 1'b0;
            reset_type_select_next = 1'b0;
          end
        end
      end
      GTI_STANDBY:
      begin
        if (nmi_wake)
        begin
          pwr_next = GTI_WAKE;
        end
      end
      GTI_WAKE:
      begin
        if (wrap)
        begin
          pwr_next = GTI_RUN;
        end
      end
      default: pwr_next = GTI_RUN;
    endcase
    if (bus.rd)
    begin
      case (bus.addr)
        GTI_ADDR_CTRL: rdata_next = {ovf_reg, ctrl_reg.mode_wd, ctrl_reg.run_en, 2'b11,
                                     ctrl_reg.prescale_select} | GTI_CTRL_RSV;
        GTI_ADDR_CNT: rdata_next = cnt_reg;
        GTI_ADDR_RST_RD: rdata_next = {watch_overflow_flag_reg, chip_reset_enable_reg, reset_type_select_reg, 5'h1F} | GTI_RST_RSV;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= '0;
      ovf_reg <= 1'b0;
      cnt_reg <= 8'h00;
      watch_overflow_flag_reg <= 1'b0;
      chip_reset_enable_reg <= 1'b0;
      reset_type_select_reg <= 1'b0;
      pre_reg <= '0;
      pin_cnt_reg <= 12'h000;
      rst_cnt_reg <= 12'h000;
      manual_reg <= 1'b0;
      pwr_reg <= GTI_RUN;
      irq_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 8'h00;
      overflow_out_n <= 1'b1;
      chip_reset <= 1'b0;
      chip_reset_manual <= 1'b0;
      standby_active <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      ovf_reg <= ovf_next;
      cnt_reg <= cnt_next;
      watch_overflow_flag_reg <= watch_overflow_flag_next;
      chip_reset_enable_reg <= chip_reset_enable_next;
      reset_type_select_reg <= reset_type_select_next;
      pre_reg <= pre_next;
      pin_cnt_reg <= pin_cnt_next;
      rst_cnt_reg <= rst_cnt_next;
      manual_reg <= manual_next;
      pwr_reg <= pwr_next;
      irq_reg <= irq_next;
      refused_reg <= refused_next;
      rdata_reg <= rdata_next;
      overflow_out_n <= (pin_cnt_next == 12'h000);
      chip_reset <= (rst_cnt_next != 12'h000);
      chip_reset_manual <= (rst_cnt_next != 12'h000) && manual_next;
      standby_active <= (pwr_next != GTI_RUN);
    end
  end

  assign rdata = rdata_reg;
  assign interval_irq = irq_reg;
  assign standby_refused = refused_reg;
endmodule

// ---- tb/gti_timer_asserts.sv ----
`timescale 1ns/1ps
// ******************
// Port checker
// ******************
module gti_timer_asserts
  import gti_pkg::*;
#(
  parameter int PIN_CYCLES = 128,
  parameter int CHIP_RST_CYCLES = 512
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire gti_bus_t bus,
  input wire logic standby_req,
  input wire logic nmi_wake,
  input wire logic [7:0] rdata,
  input wire logic overflow_out_n,
  input wire logic interval_irq,
  input wire logic chip_reset,
  input wire logic chip_reset_manual,
  input wire logic standby_active,
  input wire logic standby_refused
);
  int pc = 0;
  int rc = 0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_pin_fall;
    $fell(overflow_out_n);
  endsequence
  sequence s_rst_rise;
    $rose(chip_reset);
  endsequence
  always_ff @(posedge mclk)
  begin
    pc <= overflow_out_n ? 0 : pc + 1;
    rc <= chip_reset ? rc + 1 : 0;
  end
  a_pin_low_time: assert property ($rose(overflow_out_n) |-> pc == PIN_CYCLES)
    else $error("overflow pin low time wrong");
  a_pin_low_bound: assert property (pc <= PIN_CYCLES)
    else $error("overflow pin low too long");
  a_chip_reset_time: assert property ($fell(chip_reset) |-> rc == CHIP_RST_CYCLES)
    else $error("chip reset length wrong");
  a_reset_with_pin: assert property (s_rst_rise |-> s_pin_fall)
    else $error("chip reset not with overflow pin");
  a_manual_needs_reset: assert property (chip_reset_manual |-> chip_reset)
    else $error("manual type without chip reset");
  a_irq_one_cycle: assert property (interval_irq |=> !interval_irq)
    else $error("interrupt pulse too long");
  a_irq_no_pin: assert property (interval_irq |-> overflow_out_n)
    else $error("interrupt with overflow pin");
  a_read_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data without read");
  a_refuse_cause: assert property (standby_refused |-> $past(standby_req) && !standby_active)
    else $error("refusal without request");
  a_standby_quiet: assert property (standby_active |-> !$fell(overflow_out_n) && !interval_irq)
    else $error("overflow event in standby");
endmodule
bind gti_timer gti_timer_asserts #(.PIN_CYCLES(PIN_CYCLES), .CHIP_RST_CYCLES(CHIP_RST_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .bus(bus), .standby_req(standby_req), .nmi_wake(nmi_wake),
  .rdata(rdata), .overflow_out_n(overflow_out_n), .interval_irq(interval_irq), .chip_reset(chip_reset),
  .chip_reset_manual(chip_reset_manual), .standby_active(standby_active), .standby_refused(standby_refused));

// ---- tb/gti_timer_bench.sv ----
`timescale 1ns/1ps
// ******************
// Bench
// ******************
module gti_timer_bench
  import gti_pkg::*;
;
  logic mclk;
  logic rst_b;
  gti_bus_t bus;
  logic standby_req;
  logic nmi_wake;
  logic [7:0] rdata;
  logic overflow_out_n;
  logic interval_irq;
  logic chip_reset;
  logic chip_reset_manual;
  logic standby_active;
  logic standby_refused;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  gti_timer #(.PIN_CYCLES(4), .CHIP_RST_CYCLES(8)) uut (
    .mclk(mclk), .rst_b(rst_b), .bus(bus), .standby_req(standby_req), .nmi_wake(nmi_wake),
    .rdata(rdata), .overflow_out_n(overflow_out_n), .interval_irq(interval_irq), .chip_reset(chip_reset),
    .chip_reset_manual(chip_reset_manual), .standby_active(standby_active), .standby_refused(standby_refused));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [15:0] d, input logic w);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, word: w, addr: a, wdata: d};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [27:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, word: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic strobe(input logic [1:0] s);
    @(posedge mclk);
    {nmi_wake, standby_req} <= s;
    @(posedge mclk);
    {nmi_wake, standby_req} <= 2'b00;
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    bus = '0;
    standby_req = 1'b0;
    nmi_wake = 1'b0;
    rst_b = 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    rd(GTI_ADDR_CTRL, 8'h18);
    rd(GTI_ADDR_RST_RD, 8'h1F);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'h77}, 1'b0);
    wr(GTI_ADDR_CTRL, {8'h00, 8'h77}, 1'b1);
    rd(GTI_ADDR_CNT, 8'h00);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h38}, 1'b1);
    for (n = 0; n < 600 && !interval_irq; n++) @(posedge mclk);
    chk({7'h0, n > 495 && n < 525}, 8'h01);
    rd(GTI_ADDR_CTRL, 8'hB8);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h38}, 1'b1);
    rd(GTI_ADDR_CTRL, 8'h38);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'hFE}, 1'b1);
    for (n = 0; n < 600 && !interval_irq; n++) @(posedge mclk);
    chk({7'h0, n < 8}, 8'h01);
    strobe(2'b01);
    chk({7'h0, standby_refused}, 8'h01);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h18}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h39}, 1'b1);
    repeat (62) @(posedge mclk);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'hFE}, 1'b1);
    rd(GTI_ADDR_CNT, 8'hFE);
    for (n = 0; n < 600 && !interval_irq; n++) @(posedge mclk);
    chk({7'h0, n > 120 && n < 134}, 8'h01);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h18}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h78}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'hF0}, 1'b1);
    for (n = 0; n < 600 && overflow_out_n; n++) @(posedge mclk);
    chk({6'h0, n > 26 && n < 42, chip_reset}, 8'h02);
    rd(GTI_ADDR_CTRL, 8'h18);
    rd(GTI_ADDR_RST_RD, 8'h9F);
    wr(GTI_ADDR_RST_WR, {GTI_KEY_CNT, 8'h40}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h78}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'hFE}, 1'b1);
    for (n = 0; n < 600 && !chip_reset; n++) @(posedge mclk);
    chk({6'h0, chip_reset, chip_reset_manual}, 8'h02);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h18}, 1'b1);
    rd(GTI_ADDR_RST_RD, 8'hDF);
    wr(GTI_ADDR_RST_WR, {GTI_KEY_CTRL, 8'h00}, 1'b1);
    rd(GTI_ADDR_RST_RD, 8'h5F);
    wr(GTI_ADDR_RST_WR, {GTI_KEY_CNT, 8'h60}, 1'b1);
    rd(GTI_ADDR_RST_RD, 8'h7F);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CTRL, 8'h78}, 1'b1);
    wr(GTI_ADDR_CTRL, {GTI_KEY_CNT, 8'hFE}, 1'b1);
    for (n = 0; n < 600 && !chip_reset; n++) @(posedge mclk);
    chk({7'h0, chip_reset_manual}, 8'h01);
    rd(GTI_ADDR_RST_RD, 8'hFF);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(GTI_ADDR_RST_RD, 8'h1F);
    strobe(2'b01);
    chk({7'h0, standby_active}, 8'h01);
    strobe(2'b10);
    for (n = 0; n < 1000 && standby_active; n++) @(posedge mclk);
    chk({7'h0, n > 400 && n < 600}, 8'h01);
    print_verdict;
  end
endmodule
